// ---- rtl/cmd_fifo.sv ----
`timescale 1ns/10ps
module cmd_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic en_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;

  wire push = en_i & in_valid_i & in_ready_o;
  wire pop = en_i & out_valid_o & out_ready_i;
  wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  wire [AW-1:0] next_rd_ptr = rd_ptr + AW'(pop);
  // Head is registered; a word written into the head slot bypasses the array
  wire head_bypass = push & (wr_ptr == next_rd_ptr);
  wire [WIDTH-1:0] next_head = head_bypass ? in_data_i : mem[next_rd_ptr];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (en_i) begin
      out_data_o <= next_head;
    end
  end

  // Flags are registered so that both ready and valid leave from flops
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_o <= 1'b0;
      out_valid_o <= 1'b0;
    end else if (en_i) begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      count <= next_count;
      in_ready_o <= next_count != FULL_COUNT;
      out_valid_o <= next_count != '0;
    end
  end
endmodule

// ---- rtl/isp_pkg.sv ----
package isp_pkg;
  localparam logic [7:0] PREAMBLE = 8'haa;
  localparam logic [7:0] OP_READ_STATUS = 8'h60;
  localparam logic [2:0] IDX_PREAMBLE = 3'h0;
  localparam logic [2:0] IDX_OPCODE = 3'h1;
  localparam logic [2:0] IDX_ADDR_HI = 3'h2;
  localparam logic [2:0] IDX_ADDR_LO = 3'h3;
  localparam logic [2:0] IDX_DATA = 3'h4;
  localparam logic [2:0] CMD_BYTES = 3'h5;
  localparam logic [2:0] BYTE_CNT_MAX = 3'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam int FIFO_DEPTH = 16;

  typedef struct packed {
    logic [7:0] opcode;
    logic [15:0] addr;
    logic [7:0] data;
  } cmd_t;

  localparam int CMD_W = $bits(cmd_t);
  localparam cmd_t CMD_RESET = '{opcode: 8'h00, addr: 16'h0000, data: 8'h00};

  typedef struct packed {
    logic sck;
    logic mosi;
    logic ss_n;
    logic prog;
  } pins_t;

  localparam pins_t PINS_RESET = '{sck: 1'b0, mosi: 1'b0, ss_n: 1'b1,
                                   prog: 1'b0};

  typedef enum logic [1:0] {
    ST_OFF,
    ST_IDLE,
    ST_FRAME
  } link_state_t;
endpackage

// ---- rtl/isp_serial_port.sv ----
// What this block does
// - All bytes shift most significant bit first
// - MISO changes on falling SCK while selected
// - MOSI captured on rising SCK while selected
// - Command acted on only when select rises
// - Commands in on MOSI, read data out MISO
// - Serial port forwards the full command set
// - Command is preamble, opcode, address high, low, data
// - Opcode 60h returns memory status bits 7:1 and the pending flag as bit 0 in data byte
`timescale 1ns/10ps
module isp_serial_port (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic en_i,
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic ss_n_i,
  input wire logic prog_i,
  output logic miso_o,
  output logic miso_oe_n_o,
  input wire logic [7:0] status_i,
  input wire logic [7:0] rd_data_i,
  output logic [7:0] cur_opcode_o,
  output logic [15:0] cur_addr_o,
  output isp_pkg::cmd_t cmd_o,
  output logic cmd_valid_o,
  input wire logic cmd_ready_i,
  output logic drop_o,
  output logic prog_active_o
);
  import isp_pkg::*;

  pins_t meta;
  pins_t pins;
  logic sck_prev;
  link_state_t state;
  logic [6:0] rx_shift;
  logic [6:0] tx_shift;
  logic [2:0] bit_cnt;
  logic [2:0] byte_cnt;
  logic bad_preamble;
  cmd_t cur;
  cmd_t pend_cmd;
  logic pending;
  logic fifo_ready;

  // Edges come from the second sync stage, never from the first
  wire sck_rise = pins.sck & ~sck_prev;
  wire sck_fall = ~pins.sck & sck_prev;
  wire in_frame = state == ST_FRAME;
  wire shift_in = en_i & in_frame & sck_rise;
  wire shift_out = en_i & in_frame & sck_fall;
  wire [7:0] rx_byte = {rx_shift, pins.mosi};
  wire byte_done = shift_in & (bit_cnt == BIT_LAST);
  wire frame_end = en_i & in_frame & (pins.ss_n | ~pins.prog);
  wire cmd_ok = (byte_cnt == CMD_BYTES) & ~bad_preamble;
  wire accept = frame_end & pins.ss_n & pins.prog & cmd_ok;
  wire push = en_i & pending & fifo_ready;
  wire is_status = cur.opcode == OP_READ_STATUS;
  // Bit 0 of the status byte reports a command still waiting in the holding slot for the FIFO
  wire [7:0] resp = is_status ? {status_i[7:1], pending}
                              : rd_data_i;
  wire load_resp = (byte_cnt == IDX_DATA) & (bit_cnt == BIT_FIRST);
  wire [7:0] tx_word = load_resp ? resp : {tx_shift, 1'b0};
  wire [2:0] next_byte_cnt = (byte_cnt == BYTE_CNT_MAX) ? byte_cnt
                                                         : byte_cnt + 3'h1;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta <= PINS_RESET;
      pins <= PINS_RESET;
      sck_prev <= 1'b0;
    end else if (en_i) begin
      meta <= '{sck: sck_i, mosi: mosi_i, ss_n: ss_n_i, prog: prog_i};
      pins <= meta;
      sck_prev <= pins.sck;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= ST_OFF;
    end else if (en_i) begin
      case (state)
        ST_OFF: begin
          if (pins.prog) begin
            state <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (!pins.prog) begin
            state <= ST_OFF;
          end else if (!pins.ss_n) begin
            state <= ST_FRAME;
          end
        end
        ST_FRAME: begin
          if (!pins.prog) begin
            state <= ST_OFF;
          end else if (pins.ss_n) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_OFF;
        end
      endcase
    end
  end

  // Counters restart on every enabled clock while the frame is not open
  always_ff @(posedge clk_i) begin
    if (reset_i || (en_i && !in_frame)) begin
      bit_cnt <= BIT_FIRST;
      byte_cnt <= IDX_PREAMBLE;
      rx_shift <= '0;
      bad_preamble <= 1'b0;
    end else if (shift_in) begin
      bit_cnt <= bit_cnt + 3'h1;
      rx_shift <= rx_byte[6:0];
      if (byte_done) begin
        byte_cnt <= next_byte_cnt;
        if (byte_cnt == IDX_PREAMBLE && rx_byte != PREAMBLE) begin
          bad_preamble <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cur <= CMD_RESET;
    end else if (byte_done) begin
      case (byte_cnt)
        IDX_OPCODE: cur.opcode <= rx_byte;
        IDX_ADDR_HI: cur.addr[15:8] <= rx_byte;
        IDX_ADDR_LO: cur.addr[7:0] <= rx_byte;
        IDX_DATA: cur.data <= rx_byte;
        default: cur <= cur;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i || (en_i && !in_frame)) begin
      miso_o <= 1'b0;
      tx_shift <= '0;
    end else if (shift_out) begin
      miso_o <= tx_word[7];
      tx_shift <= tx_word[6:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      miso_oe_n_o <= 1'b1;
      prog_active_o <= 1'b0;
      cur_opcode_o <= '0;
      cur_addr_o <= '0;
    end else if (en_i) begin
      miso_oe_n_o <= ~(in_frame & ~pins.ss_n & pins.prog);
      prog_active_o <= state != ST_OFF;
      cur_opcode_o <= cur.opcode;
      cur_addr_o <= cur.addr;
    end
  end

  // A single holding slot; a second command arriving while it waits is lost unless the slot pushes into the FIFO that cycle
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pending <= 1'b0;
      pend_cmd <= CMD_RESET;
      drop_o <= 1'b0;
    end else if (en_i) begin
      drop_o <= accept & pending & ~push;
      if (accept && (!pending || push)) begin
        pending <= 1'b1;
        pend_cmd <= cur;
      end else if (push) begin
        pending <= 1'b0;
      end
    end
  end

  cmd_fifo #(
    .WIDTH(CMD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .en_i(en_i),
    .in_data_i(pend_cmd),
    .in_valid_i(pending),
    .in_ready_o(fifo_ready),
    .out_data_o(cmd_o),
    .out_valid_o(cmd_valid_o),
    .out_ready_i(cmd_ready_i)
  );

  a_hiz_deselect: assert property (@(posedge clk_i) disable iff (reset_i)
    en_i && pins.ss_n |=> miso_oe_n_o)
    else $error("MISO driven while deselected");

  a_idle_no_prog: assert property (@(posedge clk_i) disable iff (reset_i)
    en_i && !pins.prog |=> !in_frame)
    else $error("Frame open without reset pin high");

  a_capture_rise: assert property (@(posedge clk_i) disable iff (reset_i)
    shift_in && bit_cnt != BIT_LAST |=> bit_cnt == $past(bit_cnt) + 3'h1)
    else $error("Bit not counted on rising clock");

  a_opcode_msb: assert property (@(posedge clk_i) disable iff (reset_i)
    byte_done && byte_cnt == IDX_OPCODE |=> cur.opcode == $past(rx_byte))
    else $error("Opcode not assembled MSB first");

  a_miso_on_fall: assert property (@(posedge clk_i) disable iff (reset_i)
    $changed(miso_o) && in_frame |-> $past(shift_out))
    else $error("MISO changed off a falling edge");

  a_status_msb: assert property (@(posedge clk_i) disable iff (reset_i)
    shift_out && load_resp && is_status |=> miso_o == $past(status_i[7]))
    else $error("Status MSB not presented");

  a_accept_on_ss: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(pending) |-> $past(pins.ss_n) && $past(state) == ST_FRAME)
    else $error("Command taken without select rising");

  a_short_cmd: assert property (@(posedge clk_i) disable iff (reset_i)
    frame_end && byte_cnt != CMD_BYTES && !pending |=> !pending)
    else $error("Short command was accepted");

  a_push_clears: assert property (@(posedge clk_i) disable iff (reset_i)
    push && !accept |=> !pending && cmd_valid_o)
    else $error("Pending command not handed to FIFO");

  c_command: cover property (@(posedge clk_i) disable iff (reset_i)
    accept ##[1:20] cmd_valid_o);
  c_status: cover property (@(posedge clk_i) disable iff (reset_i)
    shift_out && load_resp && is_status);
  c_drop: cover property (@(posedge clk_i) disable iff (reset_i) drop_o);
  c_full: cover property (@(posedge clk_i) disable iff (reset_i)
    pending && !fifo_ready);
endmodule

// ---- sim/isp_programmer.sv ----
`timescale 1ns/10ps
module isp_programmer (
  input wire logic clk_i,
  input wire logic miso_i,
  input wire logic miso_oe_n_i,
  output logic sck_o,
  output logic mosi_o,
  output logic ss_n_o,
  output logic prog_o
);
  initial begin
    sck_o = 1'b0;
    mosi_o = 1'b0;
    ss_n_o = 1'b1;
    prog_o = 1'b0;
  end

  task automatic clks(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic enter();
    @(posedge clk_i);
    ss_n_o <= 1'b1;
    clks(2);
    prog_o <= 1'b1;
    clks(2);
    sck_o <= 1'b0;
    clks(10);
  endtask

  task automatic leave();
    @(posedge clk_i);
    ss_n_o <= 1'b1;
    mosi_o <= ~mosi_o;
    clks(2);
    prog_o <= 1'b0;
    clks(10);
  endtask

  // SCK is 4 clocks low, 4 high; MISO is read just before each fall
  task automatic frame(input logic [47:0] tx, input int nbits,
                       output logic [39:0] rx);
    rx = '0;
    @(posedge clk_i);
    ss_n_o <= 1'b0;
    clks(6);
    for (int i = nbits - 1; i >= 0; i--) begin
      mosi_o <= tx[i];
      clks(4);
      sck_o <= 1'b1;
      clks(4);
      rx = {rx[38:0], miso_oe_n_i ? 1'bx : miso_i};
      sck_o <= 1'b0;
    end
    clks(6);
    // Released MOSI must not look like the last bit
    mosi_o <= ~mosi_o;
    ss_n_o <= 1'b1;
    clks(8);
  endtask
endmodule

// ---- sim/isp_serial_port_tb.sv ----
`timescale 1ns/10ps
module isp_serial_port_tb;
  import isp_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic cmd_ready_i = 1'b0;
  logic [7:0] status_i = 8'ha5;
  logic [7:0] rd_data_i = 8'h3c;
  logic sck, mosi, ss_n, prog, miso_o, miso_oe_n_o, cmd_valid_o;
  logic drop_o, prog_active_o;
  logic en_i = 1'b1;
  logic [7:0] cur_opcode;
  logic [15:0] cur_addr;
  cmd_t cmd_o;
  logic [39:0] rx;
  int error_cnt = 0;
  int samples_checked = 0;
  int drops = 0;

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (drop_o === 1'b1) drops++;

  isp_serial_port u_isp_serial_port (.clk_i(clk_i), .reset_i(reset_i),
    .en_i(en_i), .sck_i(sck), .mosi_i(mosi), .ss_n_i(ss_n), .prog_i(prog),
    .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o), .status_i(status_i),
    .rd_data_i(rd_data_i), .cur_opcode_o(cur_opcode),
    .cur_addr_o(cur_addr), .cmd_o(cmd_o),
    .cmd_valid_o(cmd_valid_o), .cmd_ready_i(cmd_ready_i), .drop_o(drop_o),
    .prog_active_o(prog_active_o));

  isp_programmer u_isp_programmer (.clk_i(clk_i), .miso_i(miso_o),
    .miso_oe_n_i(miso_oe_n_o), .sck_o(sck), .mosi_o(mosi), .ss_n_o(ss_n),
    .prog_o(prog));

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic send(input logic [47:0] tx, input int nbits);
    u_isp_programmer.frame(tx, nbits, rx);
  endtask

  // Waits for the head entry, compares it, then pops it
  task automatic pop(input cmd_t exp);
    int n;
    n = 0;
    #1;
    while (cmd_valid_o !== 1'b1) begin
      if (n == 60) begin
        error_cnt++;
        conclude();
      end
      @(posedge clk_i);
      #1;
      n++;
    end
    check("cmd", cmd_o, exp);
    @(posedge clk_i) cmd_ready_i <= 1'b1;
    @(posedge clk_i) cmd_ready_i <= 1'b0;
  endtask

  task automatic t_enter();
    #1 check("oe_n idle", miso_oe_n_o, 1'b1);
    check("active off", prog_active_o, 1'b0);
    u_isp_programmer.enter();
    #1 check("active on", prog_active_o, 1'b1);
  endtask

  task automatic t_status();
    send(40'haa_60_1234_5a, 40);
    check("status", rx[7:1], status_i[7:1]);
    check("pending bit", rx[0], 1'b0);
    pop('{opcode: 8'h60, addr: 16'h1234, data: 8'h5a});
  endtask

  task automatic t_read();
    send(40'haa_38_abcd_00, 40);
    check("read", rx[7:0], rd_data_i);
    check("opcode out", cur_opcode, 8'h38);
    check("addr out", cur_addr, 16'habcd);
    pop('{opcode: 8'h38, addr: 16'habcd, data: 8'h00});
  endtask

  task automatic t_bad();
    send(40'h55_60_0001_01, 40);
    send({40'haa_60_0002_02, 8'h02}, 48);
    // First 13 bits of aa e0: a frame cut inside its second byte
    send(40'h155c, 13);
    send(40'haa_e4_0003_c3, 40);
    pop('{opcode: 8'he4, addr: 16'h0003, data: 8'hc3});
  endtask

  task automatic t_noprog();
    u_isp_programmer.leave();
    #1 check("active gone", prog_active_o, 1'b0);
    send(40'haa_60_0004_04, 40);
    #1 check("no cmd", cmd_valid_o, 1'b0);
    check("oe_n off", miso_oe_n_o, 1'b1);
    u_isp_programmer.enter();
  endtask

  task automatic t_full();
    for (int i = 0; i < 18; i++) send({8'haa, 8'he1, 8'(i), 8'h00, 8'(i)}, 40);
    check("drops", drops, 1);
    // Clock enable low must hold the queue although the core asks to pop
    @(posedge clk_i);
    en_i <= 1'b0;
    cmd_ready_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    cmd_ready_i <= 1'b0;
    en_i <= 1'b1;
    #1 check("frozen valid", cmd_valid_o, 1'b1);
    check("frozen head", cmd_o, {8'he1, 16'h0000, 8'h00});
    for (int i = 0; i < 17; i++) pop('{opcode: 8'he1, addr: {8'(i), 8'h00},
                                      data: 8'(i)});
    #1 check("empty", cmd_valid_o, 1'b0);
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    // Power-on wait before the first command; reset_i is the internal reset
    repeat (10) @(posedge clk_i);
    t_enter();
    t_status();
    t_read();
    t_bad();
    t_noprog();
    t_status();
    t_full();
    conclude();
  end
endmodule
